// ==== src/pefg_defs.svh ====
// Constants for the port E/F/G pin function setup block
`ifndef PEFG_DEFS_SVH
`define PEFG_DEFS_SVH
`define PEFG_E_W 6
`define PEFG_F_W 8
`define PEFG_G_W 2
`define PEFG_E_DIR_RST 6'h0C
`define PEFG_E_FS1_RST 6'h30
`define PEFG_E_PU_RST 6'h20
`define PEFG_E_PD_RST 6'h10
`define PEFG_E_IE_RST 6'h30
`define PEFG_BOOT_PIN 3
`define PEFG_DBGCLK_PIN 4
`define PEFG_DBGDAT_PIN 5
`define PEFG_RXD_PIN 1
`define PEFG_CS_PIN 0
`define PEFG_SCK_PIN 0
`define PEFG_TMR_PIN 4
`define PEFG_IDLE_LEVEL 1'h0
`endif

// ==== src/pefg_pkg.sv ====
// Types for the port E/F/G pin function setup block
`include "pefg_defs.svh"
package pefg_pkg;
  // Per-port settings held by software
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] fs1;
    logic [7:0] fs2;
    logic [7:0] od;
    logic [7:0] pu;
    logic [7:0] pd;
    logic [7:0] sel;
    logic [7:0] ie;
  } pefg_cfg_t;
  // Pad-side drive for one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
  } pefg_pad_t;
  typedef enum logic [1:0] {
    PEFG_RUN = 2'h1,
    PEFG_RST = 2'h2
  } pefg_state_t;
endpackage

// ==== src/pefg_pin_setup.sv ====
// Pin function setup and pad control for ports E, F and G
`timescale 1ns/10ps
`include "pefg_defs.svh"
module pefg_pin_setup
  import pefg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Settings written by software
  input wire pefg_cfg_t cfgE,
  input wire pefg_cfg_t cfgF,
  input wire pefg_cfg_t cfgG,
  input wire logic cfgWrE,
  input wire logic cfgWrF,
  input wire logic cfgWrG,
  // Pad inputs
  input wire logic [7:0] padInE,
  input wire logic [7:0] padInF,
  input wire logic [7:0] padInG,
  // Peripheral function outputs
  input wire logic csOut,
  input wire logic timer3Out,
  input wire logic [1:0] i2cDriveLow,
  input wire logic dbgDataOut,
  input wire logic dbgDataOe,
  // Pad drive
  output pefg_pad_t padE_ff,
  output pefg_pad_t padF_ff,
  output pefg_pad_t padG_ff,
  // Settings readback and input data
  output pefg_cfg_t setE_ff,
  output pefg_cfg_t setF_ff,
  output pefg_cfg_t setG_ff,
  output logic [7:0] inE_ff,
  output logic [7:0] inF_ff,
  output logic [7:0] inG_ff,
  // Peripheral function inputs
  output logic serial1Clock_ff,
  output logic serial1Receive_ff,
  output logic timer2Input_ff,
  output logic csIn_ff,
  output logic [1:0] i2cIn_ff,
  output logic dbgClk_ff,
  output logic dbgData_ff,
  // Boot mode: 1 single-chip, 0 single-boot
  output logic bootSingleChip_ff
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [7:0] metaE_ff, metaF_ff, metaG_ff;
  logic [7:0] syncE_ff, syncF_ff, syncG_ff;
  pefg_state_t state_ff;
  logic bootSeen_ff;

  always_ff @(posedge clk_sys) begin
    metaE_ff <= padInE;
    metaF_ff <= padInF;
    metaG_ff <= padInG;
    syncE_ff <= metaE_ff;
    syncF_ff <= metaF_ff;
    syncG_ff <= metaG_ff;
  end

  // ------------------------------------------------------------
  // Settings registers
  // ------------------------------------------------------------
  // Clear port F and G settings on reset; port E loads its reset values
  // Port E pins 2-3 direction set
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      setE_ff <= '0;
      setE_ff.dir <= {2'h0, `PEFG_E_DIR_RST};
      setE_ff.fs1 <= {2'h0, `PEFG_E_FS1_RST};
      setE_ff.pu <= {2'h0, `PEFG_E_PU_RST};
      setE_ff.pd <= {2'h0, `PEFG_E_PD_RST};
      setE_ff.ie <= {2'h0, `PEFG_E_IE_RST};
    end else if (cfgWrE) begin
      setE_ff <= cfgE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      setF_ff <= '0;
    end else if (cfgWrF) begin
      setF_ff <= cfgF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      setG_ff <= '0;
    end else if (cfgWrG) begin
      setG_ff <= cfgG;
    end
  end

  // ------------------------------------------------------------
  // Boot mode capture
  // ------------------------------------------------------------
  // Sample boot pin at release
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= PEFG_RST;
      bootSeen_ff <= 1'h0;
    end else begin
      case (state_ff)
        PEFG_RST: begin
          state_ff <= PEFG_RUN;
          bootSeen_ff <= 1'h1;
        end
        PEFG_RUN: begin
          state_ff <= PEFG_RUN;
        end
        default: begin
          state_ff <= PEFG_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bootSingleChip_ff <= 1'h1;
    end else if (state_ff == PEFG_RST && !bootSeen_ff) begin
      bootSingleChip_ff <= syncE_ff[`PEFG_BOOT_PIN];
    end
  end

  // ------------------------------------------------------------
  // Pad drive
  // ------------------------------------------------------------
  logic [7:0] outSelE, outSelF, outSelG;
  logic [7:0] oeF, oeG, oeE;

  always_comb begin
    outSelE = setE_ff.data;
    oeE = setE_ff.dir & ~setE_ff.ie;
    if (setE_ff.fs1[`PEFG_DBGDAT_PIN]) begin
      outSelE[`PEFG_DBGDAT_PIN] = dbgDataOut;
      oeE[`PEFG_DBGDAT_PIN] = dbgDataOe;
    end
    if (setE_ff.fs1[`PEFG_DBGCLK_PIN]) begin
      oeE[`PEFG_DBGCLK_PIN] = 1'h0;
    end
    outSelF = setF_ff.data;
    oeF = setF_ff.dir & ~setF_ff.ie;
    if (setF_ff.fs1[`PEFG_CS_PIN] && setF_ff.dir[`PEFG_CS_PIN]) begin
      outSelF[`PEFG_CS_PIN] = csOut;
    end
    if (setF_ff.fs1[`PEFG_TMR_PIN] && setF_ff.dir[`PEFG_TMR_PIN]
        && !setF_ff.ie[`PEFG_TMR_PIN]) begin
      outSelF[`PEFG_TMR_PIN] = timer3Out;
    end
    outSelG = setG_ff.data;
    oeG = setG_ff.dir & ~setG_ff.ie;
    for (int i = 0; i < `PEFG_G_W; i++) begin
      if (setG_ff.fs1[i] && setG_ff.dir[i]) begin
        outSelG[i] = 1'h0;
        oeG[i] = i2cDriveLow[i];
      end
    end
    // Open drain only drives low
    oeE = oeE & ~(setE_ff.od & outSelE);
    oeF = oeF & ~(setF_ff.od & outSelF);
    oeG = oeG & ~(setG_ff.od & outSelG);
  end

  // Boot pin pull-up forced in reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      padE_ff <= '0;
      padF_ff <= '0;
      padG_ff <= '0;
      padE_ff.pu[`PEFG_BOOT_PIN] <= 1'h1;
    end else begin
      padE_ff <= '{out: outSelE, oe: oeE, pu: setE_ff.pu, pd: setE_ff.pd};
      padF_ff <= '{out: outSelF, oe: oeF, pu: setF_ff.pu, pd: setF_ff.pd};
      padG_ff <= '{out: outSelG, oe: oeG, pu: setG_ff.pu, pd: setG_ff.pd};
    end
  end

  // ------------------------------------------------------------
  // Input paths
  // ------------------------------------------------------------
  logic [7:0] gateE, gateF, gateG;
  // Inputs with ie clear read as PEFG_IDLE_LEVEL
  always_comb begin
    gateE = (syncE_ff & setE_ff.ie) | ({8{`PEFG_IDLE_LEVEL}} & ~setE_ff.ie);
    gateF = (syncF_ff & setF_ff.ie) | ({8{`PEFG_IDLE_LEVEL}} & ~setF_ff.ie);
    gateG = (syncG_ff & setG_ff.ie) | ({8{`PEFG_IDLE_LEVEL}} & ~setG_ff.ie);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      inE_ff <= '0;
      inF_ff <= '0;
      inG_ff <= '0;
    end else begin
      inE_ff <= gateE;
      inF_ff <= gateF;
      inG_ff <= gateG;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serial1Clock_ff <= 1'h0;
      serial1Receive_ff <= 1'h0;
      timer2Input_ff <= 1'h0;
      csIn_ff <= 1'h0;
      i2cIn_ff <= 2'h0;
      dbgClk_ff <= 1'h0;
      dbgData_ff <= 1'h0;
    end else begin
      serial1Clock_ff <= setE_ff.fs1[`PEFG_SCK_PIN] & ~setE_ff.dir[`PEFG_SCK_PIN]
                         & gateE[`PEFG_SCK_PIN];
      serial1Receive_ff <= setE_ff.fs1[`PEFG_RXD_PIN] & ~setE_ff.dir[`PEFG_RXD_PIN]
                           & gateE[`PEFG_RXD_PIN];
      timer2Input_ff <= setE_ff.fs2[`PEFG_RXD_PIN] & ~setE_ff.dir[`PEFG_RXD_PIN]
                        & gateE[`PEFG_RXD_PIN];
      csIn_ff <= setF_ff.fs2[`PEFG_CS_PIN] & ~setF_ff.dir[`PEFG_CS_PIN]
                 & gateF[`PEFG_CS_PIN];
      i2cIn_ff <= setG_ff.fs1[1:0] & gateG[1:0];
      dbgClk_ff <= setE_ff.fs1[`PEFG_DBGCLK_PIN] & gateE[`PEFG_DBGCLK_PIN];
      dbgData_ff <= setE_ff.fs1[`PEFG_DBGDAT_PIN] & gateE[`PEFG_DBGDAT_PIN];
    end
  end

endmodule

// ==== dv/pefg_pin_monitor.sv ====
// Assertion checker for the port E/F/G pin setup block
`timescale 1ns/10ps
module pefg_pin_monitor
  import pefg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Watched ports
  input wire pefg_cfg_t cfgF,
  input wire logic cfgWrF,
  input wire logic csOut,
  input wire logic [1:0] i2cDriveLow,
  input wire pefg_pad_t padE_ff,
  input wire pefg_pad_t padF_ff,
  input wire pefg_pad_t padG_ff,
  input wire pefg_cfg_t setE_ff,
  input wire pefg_cfg_t setF_ff,
  input wire pefg_cfg_t setG_ff,
  input wire logic [7:0] inF_ff,
  input wire logic bootSingleChip_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rst_pull_a: assert property ($rose(rst_b) |-> padE_ff == 32'h800
    && (padF_ff | padG_ff) == 32'h0) else $error("pads not quiet in reset");
  rst_set_a: assert property ($rose(rst_b) |-> setE_ff == 72'h000C30000020100030)
    else $error("port E reset settings wrong");
  rst_clear_a: assert property ($rose(rst_b) |-> (setF_ff | setG_ff) == 72'h0)
    else $error("port F or G settings not cleared");
  cfg_load_a: assert property (cfgWrF |=> setF_ff == $past(cfgF))
    else $error("settings write lost");
  out_drive_a: assert property (setF_ff.dir[7] && !(setF_ff.ie[7] | setF_ff.fs1[7]
    | setF_ff.fs2[7] | setF_ff.od[7]) |=> padF_ff.oe[7] && padF_ff.out[7] == $past(
    setF_ff.data[7])) else $error("output pin not driving data");
  in_gate_a: assert property (!setF_ff.ie[7] |=> !inF_ff[7])
    else $error("disabled input not gated");
  cs_out_a: assert property (setF_ff.fs1[0] && setF_ff.dir[0] && !setF_ff.od[0]
    && !setF_ff.ie[0] |=> padF_ff.oe[0] && padF_ff.out[0] == $past(csOut))
    else $error("chip select out");
  i2c_low_a: assert property (setG_ff.fs1[1] && setG_ff.dir[1] && i2cDriveLow[1]
    |=> padG_ff.oe[1] && !padG_ff.out[1]) else $error("bus line not pulled low");
  boot_hold_a: assert property ($past(rst_b) && $past(rst_b, 2)
    |-> $stable(bootSingleChip_ff)) else $error("boot mode changed after start");
endmodule
bind pefg_pin_setup pefg_pin_monitor u_mon (.clk_sys, .rst_b, .cfgF, .cfgWrF, .csOut,
  .i2cDriveLow, .padE_ff, .padF_ff, .padG_ff, .setE_ff, .setF_ff, .setG_ff, .inF_ff,
  .bootSingleChip_ff);

// ==== dv/pefg_board_model.sv ====
// Board model: resolves pad levels from drive, pulls and bench drivers
`timescale 1ns/10ps
module pefg_board_model
  import pefg_pkg::*;
(
  // Pad drive and bench drivers
  input wire pefg_pad_t padE_ff,
  input wire pefg_pad_t padF_ff,
  input wire pefg_pad_t padG_ff,
  input wire logic [23:0] extLvl,
  input wire logic [23:0] extEn,
  // Resolved levels
  output logic [7:0] padInE,
  output logic [7:0] padInF,
  output logic [7:0] padInG
);
  logic flip = 1'h0;
  // Undriven, unpulled pads wander
  always #3 flip = ~flip;
  function automatic logic [7:0] lvl(pefg_pad_t p, logic [7:0] l, logic [7:0] e, logic f);
    return (p.oe & p.out) | (~p.oe & e & l) | (~p.oe & ~e & (p.pu | (~p.pd & {8{f}})));
  endfunction
  assign padInE = lvl(padE_ff, extLvl[7:0], extEn[7:0], flip);
  assign padInF = lvl(padF_ff, extLvl[15:8], extEn[15:8], flip);
  assign padInG = lvl(padG_ff, extLvl[23:16], extEn[23:16], ~flip);
endmodule

// ==== dv/port_efg_pin_function_setup_tb_top.sv ====
// Testbench for the port E/F/G pin setup block
`timescale 1ns/10ps
module port_efg_pin_function_setup_tb_top
  import pefg_pkg::*;
;
  logic clk_sys = 1'h0, rst_b = 1'h0, cfgWrE, cfgWrF, cfgWrG, v;
  logic csOut, timer3Out, dbgDataOut = 1'h0, dbgDataOe = 1'h0;
  logic [1:0] i2cDriveLow, i2cIn_ff;
  logic [7:0] padInE, padInF, padInG, inE_ff, inF_ff, inG_ff;
  logic [23:0] extLvl = 24'h0, extEn = 24'h0;
  logic [31:0] seed = 32'hB581, r1, r2;
  logic serial1Clock_ff, serial1Receive_ff, timer2Input_ff, csIn_ff, dbgClk_ff, dbgData_ff;
  logic bootSingleChip_ff;
  pefg_cfg_t cfgE, cfgF, cfgG, setE_ff, setF_ff, setG_ff, c;
  pefg_pad_t padE_ff, padF_ff, padG_ff;
  int fails = 0, cmp_count = 0;
  pefg_pin_setup u_dut (.*);
  pefg_board_model u_board (.*);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task cmp(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task close_out;
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task rst_chk(input logic drv);
    extEn[3] = drv;
    rst_b = 1'h0;
    repeat (3) @(negedge clk_sys);
    cmp(setE_ff, 72'h000C30000020100030);
    cmp(setF_ff | setG_ff, 72'h0);
    cmp(padE_ff, 32'h800);
    cmp(padF_ff | padG_ff, 32'h0);
    rst_b = 1'h1;
    repeat (3) @(negedge clk_sys);
    cmp(bootSingleChip_ff, {71'h0, ~drv});
    repeat (2) @(negedge clk_sys);
    cmp(dbgClk_ff, 1'h0);
    cmp(dbgData_ff, 1'h1);
    extEn[3] = 1'h0;
  endtask
  initial begin
    {cfgE, cfgF, cfgG, cfgWrE, cfgWrF, cfgWrG} = 219'h0;
    {csOut, timer3Out, i2cDriveLow} = 4'h0;
    rst_chk(1'h1);
    repeat (20) begin
      r1 = rnd();
      r2 = rnd();
      c = {r1[15:0], 24'h0, r1[31:16], r2[15:0]};
      cfgF = c;
      cfgWrF = 1'h1;
      extEn[15:8] = ~(c.dir & ~c.ie);
      extLvl[15:8] = r2[23:16];
      @(negedge clk_sys);
      cfgWrF = 1'h0;
      @(negedge clk_sys);
      cmp(setF_ff, c);
      cmp({padF_ff.out & c.dir, padF_ff.oe, padF_ff.pu, padF_ff.pd},
        {c.data & c.dir, c.dir & ~c.ie, c.pu, c.pd});
      repeat (3) @(negedge clk_sys);
      cmp(inF_ff, r2[23:16] & c.ie);
    end
    cfgE = 72'h000002000000000002;
    cfgF = 72'h001111000000000000;
    cfgG = 72'h000303000000000003;
    extEn[17:16] = 2'h3;
    extLvl[17:16] = 2'h3;
    v = 1'h0;
    repeat (2) begin
      {cfgWrE, cfgWrF, cfgWrG} = 3'h7;
      {csOut, timer3Out, i2cDriveLow} = {v, v, v, ~v};
      extEn[1] = 1'h1;
      extLvl[1] = v;
      @(negedge clk_sys);
      {cfgWrE, cfgWrF, cfgWrG} = 3'h0;
      repeat (5) @(negedge clk_sys);
      cmp({padF_ff.out[4], padF_ff.out[0], padG_ff.oe[1:0]}, {v, v, v, ~v});
      cmp(serial1Receive_ff, v);
      cmp(i2cIn_ff, {~v, v});
      v = ~v;
    end
    rst_chk(1'h0);
    close_out();
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule
